// ===== design/aio_pkg.sv
// Shared constants and types for the analog I/O control register bank
package aio_pkg;
   // Bus geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int CODE_W = 12;

   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_SOFT_START = 8'h01;
   localparam logic [7:0] IDX_FIRST_CODE = 8'h0c;
   localparam logic [7:0] IDX_SECOND_CODE = 8'h0e;
   localparam logic [7:0] IDX_UPDATE_CFG = 8'h10;
   localparam logic [7:0] IDX_START_CFG = 8'h11;
   localparam logic [7:0] IDX_STATUS = 8'h12;
   localparam logic [7:0] IDX_INT = 8'h13;
   localparam logic [7:0] IDX_PORT_A = 8'h14;
   localparam logic [7:0] IDX_PORT_B = 8'h15;
   localparam logic [7:0] IDX_DIRECTION = 8'h17;
   localparam logic [7:0] IDX_TIMER_DIV = 8'h1c;
   localparam logic [7:0] IDX_CNT0 = 8'h1d;

   // Field positions
   localparam int SIMUL_BIT = 0;
   localparam int SRC_LOW_BIT = 0;
   localparam int SRC_HIGH_BIT = 1;
   localparam int SCAN_BIT = 2;
   localparam int POL_BIT = 3;
   localparam int CNT0_SEL_BIT = 4;
   localparam int INT_FLAG_LSB = 4;
   localparam int DIR_QUAL_BIT = 7;
   localparam int DIR_A_BIT = 4;
   localparam int DIR_B_BIT = 1;

   // Reset values
   localparam logic [7:0] START_CFG_RST = 8'h00;
   localparam logic [15:0] TIMER_DIV_RST = 16'h0a0a;
   localparam logic [1:0] DRIVE_RST = 2'b00;

   // Timing: counter 0 internal clock derived from the block clock
   localparam int CLK_HZ = 250_000_000;
   localparam int INT_CNT_HZ = 10_000_000;
   localparam int INT_TICK_CYCLES = CLK_HZ / INT_CNT_HZ;
   localparam logic [4:0] INT_TICK_LAST = 5'(INT_TICK_CYCLES - 1);

   typedef enum logic [1:0] {
      SRC_SOFT = 2'b00,
      SRC_TIMER = 2'b01,
      SRC_EXT = 2'b10,
      SRC_RSVD = 2'b11
   } aio_src_type;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } aio_bus_type;
endpackage : aio_pkg

// ===== design/aio_chain_if.sv
// Signals between the register bank and the chained counter pair
`timescale 1ns/100ps
interface aio_chain_if;
   logic [7:0] reload1;
   logic [7:0] reload2;
   logic run;
   logic polarity;
   logic c1_tick;
   logic out;
   logic out_edge;
   modport ctrl (output reload1, output reload2, output run, output polarity,
      input c1_tick, input out, input out_edge);
   modport chain (input reload1, input reload2, input run, input polarity,
      output c1_tick, output out, output out_edge);
endinterface : aio_chain_if

// ===== design/aio_timer_chain.sv
// Counter 1 feeding counter 2, the pacing source for conversion starts
`timescale 1ns/100ps
module aio_timer_chain (
   input wire logic i_clk,
   input wire logic i_rstn,
   aio_chain_if.chain ch
);
   logic [7:0] cnt1_r;
   logic [7:0] cnt2_r;
   logic tick_r;
   logic out_r;
   logic edge_r;

   // Counter 1, one tick per reload1+1 clocks
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt1_r <= 8'h00;
         tick_r <= 1'b0;
      end else if (!ch.run) begin
         cnt1_r <= ch.reload1;
         tick_r <= 1'b0;
      end else if (cnt1_r == 8'h00) begin
         cnt1_r <= ch.reload1;
         tick_r <= 1'b1;
      end else begin
         cnt1_r <= cnt1_r - 8'h01;
         tick_r <= 1'b0;
      end
   end

   // Counter 2 steps only on counter 1 output
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt2_r <= 8'h00;
         out_r <= 1'b0;
      end else if (!ch.run) begin
         cnt2_r <= ch.reload2;
         out_r <= 1'b0;
      end else if (tick_r) begin
         if (cnt2_r == 8'h00) begin
            cnt2_r <= ch.reload2;
            out_r <= ~out_r;
         end else begin
            cnt2_r <= cnt2_r - 8'h01;
         end
      end
   end

   // Edge of counter 2 output in the chosen polarity
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         edge_r <= 1'b0;
      end else begin
         edge_r <= ch.run && tick_r && (cnt2_r == 8'h00) && (out_r == ch.polarity);
      end
   end

   assign ch.c1_tick = tick_r;
   assign ch.out = out_r;
   assign ch.out_edge = edge_r;

   a_chain_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ch.run && !tick_r |=> cnt2_r == $past(cnt2_r))
      else $error("counter 2 moved without a counter 1 tick");
   a_chain_toggle: assert property (@(posedge i_clk) disable iff (!i_rstn)
      ch.run && tick_r && cnt2_r == 8'h00 |=> out_r != $past(out_r))
      else $error("counter 2 output did not toggle at terminal count");
endmodule : aio_timer_chain

// ===== design/aio_regs.sv
// Register bank of the analog I/O board on an Avalon-MM slave port
`timescale 1ns/100ps
module aio_regs (
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic [9:0] I_AVS_ADDRESS,
   input wire logic I_AVS_READ,
   input wire logic I_AVS_WRITE,
   input wire logic [31:0] I_AVS_WRITEDATA,
   input wire logic [3:0] I_AVS_BYTEENABLE,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   input wire logic I_BIPOLAR,
   input wire logic I_SINGLE_ENDED,
   input wire logic I_HIGH_GAIN_JUMPER,
   input wire logic I_FIRST_OUTPUT_RANGE,
   input wire logic I_SECOND_OUTPUT_RANGE,
   input wire logic I_QUEUE_EMPTY,
   input wire logic I_QUEUE_HALF,
   input wire logic I_QUEUE_FULL,
   input wire logic I_CONV_DONE,
   input wire logic I_SCAN_DONE,
   input wire logic I_EXT_TRIGGER,
   input wire logic I_CNT0_EXT_CLK,
   input wire logic [7:0] I_PORT_A_IN,
   input wire logic [7:0] I_PORT_B_IN,
   output logic [11:0] O_FIRST_OUTPUT_CODE,
   output logic [11:0] O_SECOND_OUTPUT_CODE,
   output logic O_CONV_START,
   output logic O_SCAN_SELECT,
   output logic O_CHAIN_OUT,
   output logic O_IRQ,
   output logic [7:0] O_PORT_A_OUT,
   output logic [7:0] O_PORT_A_OE,
   output logic [7:0] O_PORT_B_OUT,
   output logic [7:0] O_PORT_B_OE
);
   aio_pkg::aio_bus_type bus_state_r;
   logic wait_r;
   logic [31:0] rdata_r;
   logic [31:0] rd_mux;
   logic [7:0] cur_idx;
   logic acc_wr;
   logic acc_rd;
   logic simul_r;
   logic [7:0] start_cfg_r;
   aio_pkg::aio_src_type src;
   logic [11:0] first_stage_r;
   logic [11:0] first_out_r;
   logic [11:0] second_out_r;
   logic [11:0] first_nxt;
   logic [11:0] second_nxt;
   logic [15:0] timer_div_r;
   logic armed_r;
   logic trig_d_r;
   logic trig_edge;
   logic start_r;
   logic [4:0] tick_div_r;
   logic int_tick_r;
   logic ext_d_r;
   logic [15:0] cnt0_r;
   logic [3:0] int_en_r;
   logic [3:0] flags_r;
   logic [3:0] set_vec;
   logic [3:0] clr_vec;
   logic half_d_r;
   logic full_d_r;
   logic irq_r;
   logic [7:0] port_out_r [2];
   logic [1:0] drive_r;
   logic [7:0] port_pin [2];

   aio_chain_if chain_if ();

   // Write hit on one byte register
   function automatic logic byte_hit(input logic [7:0] target);
      return acc_wr && I_AVS_BYTEENABLE[0] && (cur_idx == target);
   endfunction : byte_hit

   // Merge the enabled lanes of a 12-bit code, upper nibble of lane 1 dropped
   function automatic logic [11:0] merge_code(input logic [11:0] old);
      logic [11:0] res;
      res = old;
      if (I_AVS_BYTEENABLE[0]) begin
         res[7:0] = I_AVS_WRITEDATA[7:0];
      end
      if (I_AVS_BYTEENABLE[1]) begin
         res[11:8] = I_AVS_WRITEDATA[11:8];
      end
      return res;
   endfunction : merge_code

   assign cur_idx = I_AVS_ADDRESS[9:2];
   assign acc_wr = (bus_state_r == aio_pkg::BUS_ANSWER) && I_AVS_WRITE;
   assign acc_rd = (bus_state_r == aio_pkg::BUS_ANSWER) && I_AVS_READ;
   assign src = aio_pkg::aio_src_type'({start_cfg_r[aio_pkg::SRC_HIGH_BIT],
      start_cfg_r[aio_pkg::SRC_LOW_BIT]});

   // Bus handshake: one wait cycle, answer, then back to idle
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         bus_state_r <= aio_pkg::BUS_IDLE;
         wait_r <= 1'b1;
         rdata_r <= 32'h0;
      end else begin
         case (bus_state_r)
            aio_pkg::BUS_IDLE: begin
               if (I_AVS_READ || I_AVS_WRITE) begin
                  bus_state_r <= aio_pkg::BUS_ANSWER;
                  wait_r <= 1'b0;
                  if (I_AVS_READ) begin
                     rdata_r <= rd_mux;
                  end
               end
            end
            aio_pkg::BUS_ANSWER: begin
               bus_state_r <= aio_pkg::BUS_IDLE;
               wait_r <= 1'b1;
            end
            default: begin
               bus_state_r <= aio_pkg::BUS_IDLE;
               wait_r <= 1'b1;
            end
         endcase
      end
   end

   // Read data selection, unmapped and write-only registers read zero
   always_comb begin
      rd_mux = 32'h0;
      case (cur_idx)
         aio_pkg::IDX_STATUS: begin
            rd_mux[7:0] = {~I_QUEUE_FULL, ~I_QUEUE_HALF, ~I_QUEUE_EMPTY,
               I_SECOND_OUTPUT_RANGE, I_FIRST_OUTPUT_RANGE,
               I_HIGH_GAIN_JUMPER, I_SINGLE_ENDED, I_BIPOLAR};
         end
         aio_pkg::IDX_INT: begin
            rd_mux[7:4] = flags_r;
         end
         aio_pkg::IDX_PORT_A: begin
            rd_mux[7:0] = drive_r[0] ? port_out_r[0] : I_PORT_A_IN;
         end
         aio_pkg::IDX_PORT_B: begin
            rd_mux[7:0] = drive_r[1] ? port_out_r[1] : I_PORT_B_IN;
         end
         aio_pkg::IDX_TIMER_DIV: begin
            rd_mux[15:0] = timer_div_r;
         end
         aio_pkg::IDX_CNT0: begin
            rd_mux[15:0] = cnt0_r;
         end
         default: begin
            rd_mux = 32'h0;
         end
      endcase
   end

   // Configuration registers
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         simul_r <= 1'b0;
         start_cfg_r <= aio_pkg::START_CFG_RST;
         timer_div_r <= aio_pkg::TIMER_DIV_RST;
         int_en_r <= 4'h0;
      end else begin
         if (byte_hit(aio_pkg::IDX_UPDATE_CFG)) begin
            simul_r <= I_AVS_WRITEDATA[aio_pkg::SIMUL_BIT];
         end
         if (byte_hit(aio_pkg::IDX_START_CFG)) begin
            start_cfg_r <= I_AVS_WRITEDATA[7:0];
         end
         if (byte_hit(aio_pkg::IDX_INT)) begin
            int_en_r <= I_AVS_WRITEDATA[3:0];
         end
         if (acc_wr && cur_idx == aio_pkg::IDX_TIMER_DIV) begin
            if (I_AVS_BYTEENABLE[0]) begin
               timer_div_r[7:0] <= I_AVS_WRITEDATA[7:0];
            end
            if (I_AVS_BYTEENABLE[1]) begin
               timer_div_r[15:8] <= I_AVS_WRITEDATA[15:8];
            end
         end
      end
   end

   assign first_nxt = merge_code(first_stage_r);
   assign second_nxt = merge_code(second_out_r);

   // Output codes, staged or immediate
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         first_stage_r <= 12'h000;
         first_out_r <= 12'h000;
         second_out_r <= 12'h000;
      end else begin
         if (acc_wr && cur_idx == aio_pkg::IDX_FIRST_CODE) begin
            first_stage_r <= first_nxt;
            if (!simul_r) begin
               first_out_r <= first_nxt;
            end
         end
         if (acc_wr && cur_idx == aio_pkg::IDX_SECOND_CODE) begin
            second_out_r <= second_nxt;
            if (simul_r) begin
               first_out_r <= first_stage_r;
            end
         end
      end
   end

   // Trigger arming and start pulse generation
   assign trig_edge = start_cfg_r[aio_pkg::POL_BIT] ? (trig_d_r && !I_EXT_TRIGGER)
      : (!trig_d_r && I_EXT_TRIGGER);
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         trig_d_r <= 1'b0;
         armed_r <= 1'b0;
         start_r <= 1'b0;
      end else begin
         trig_d_r <= I_EXT_TRIGGER;
         if (src != aio_pkg::SRC_EXT) begin
            armed_r <= 1'b0;
         end else if (trig_edge) begin
            armed_r <= 1'b1;
         end
         case (src)
            aio_pkg::SRC_SOFT: start_r <= byte_hit(aio_pkg::IDX_SOFT_START);
            aio_pkg::SRC_TIMER: start_r <= chain_if.out_edge;
            aio_pkg::SRC_EXT: start_r <= chain_if.out_edge;
            default: start_r <= 1'b0;
         endcase
      end
   end

   assign chain_if.reload1 = timer_div_r[7:0];
   assign chain_if.reload2 = timer_div_r[15:8];
   assign chain_if.polarity = start_cfg_r[aio_pkg::POL_BIT];
   assign chain_if.run = (src == aio_pkg::SRC_TIMER) || (src == aio_pkg::SRC_EXT && armed_r);

   aio_timer_chain u_chain (
      .i_clk(I_CLK),
      .i_rstn(I_RSTN),
      .ch(chain_if.chain)
   );

   // Counter 0 with selectable clock source
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         tick_div_r <= 5'h00;
         int_tick_r <= 1'b0;
         ext_d_r <= 1'b0;
         cnt0_r <= 16'h0000;
      end else begin
         int_tick_r <= (tick_div_r == aio_pkg::INT_TICK_LAST);
         tick_div_r <= (tick_div_r == aio_pkg::INT_TICK_LAST) ? 5'h00 : tick_div_r + 5'h01;
         ext_d_r <= I_CNT0_EXT_CLK;
         if (start_cfg_r[aio_pkg::CNT0_SEL_BIT] ? (I_CNT0_EXT_CLK && !ext_d_r)
            : int_tick_r) begin
            cnt0_r <= cnt0_r + 16'h0001;
         end
      end
   end

   // Interrupt causes, set wins over read clear
   assign set_vec = {I_QUEUE_FULL && !full_d_r, I_QUEUE_HALF && !half_d_r,
      I_SCAN_DONE, I_CONV_DONE} & int_en_r;
   assign clr_vec = (acc_rd && cur_idx == aio_pkg::IDX_INT) ? rdata_r[7:4] : 4'h0;
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         half_d_r <= 1'b0;
         full_d_r <= 1'b0;
         flags_r <= 4'h0;
         irq_r <= 1'b0;
      end else begin
         half_d_r <= I_QUEUE_HALF;
         full_d_r <= I_QUEUE_FULL;
         flags_r <= (flags_r & ~clr_vec) | set_vec;
         irq_r <= |((flags_r & ~clr_vec) | set_vec);
      end
   end

   // Port direction, ignored unless the qualifier bit is set
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         drive_r <= aio_pkg::DRIVE_RST;
      end else if (byte_hit(aio_pkg::IDX_DIRECTION)
         && I_AVS_WRITEDATA[aio_pkg::DIR_QUAL_BIT]) begin
         drive_r[0] <= !I_AVS_WRITEDATA[aio_pkg::DIR_A_BIT];
         drive_r[1] <= !I_AVS_WRITEDATA[aio_pkg::DIR_B_BIT];
      end
   end

   // Port output latches
   assign port_pin[0] = I_PORT_A_IN;
   assign port_pin[1] = I_PORT_B_IN;
   for (genvar p = 0; p < 2; p++) begin : g_port
      always_ff @(posedge I_CLK or negedge I_RSTN) begin
         if (!I_RSTN) begin
            port_out_r[p] <= 8'h00;
         end else if (byte_hit(p == 0 ? aio_pkg::IDX_PORT_A : aio_pkg::IDX_PORT_B)) begin
            port_out_r[p] <= I_AVS_WRITEDATA[7:0];
         end
      end
   end

   assign O_AVS_READDATA = rdata_r;
   assign O_AVS_WAITREQUEST = wait_r;
   assign O_FIRST_OUTPUT_CODE = first_out_r;
   assign O_SECOND_OUTPUT_CODE = second_out_r;
   assign O_CONV_START = start_r;
   assign O_SCAN_SELECT = start_cfg_r[aio_pkg::SCAN_BIT];
   assign O_CHAIN_OUT = chain_if.out;
   assign O_IRQ = irq_r;
   assign O_PORT_A_OUT = port_out_r[0];
   assign O_PORT_A_OE = {8{drive_r[0]}};
   assign O_PORT_B_OUT = port_out_r[1];
   assign O_PORT_B_OE = {8{drive_r[1]}};

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RSTN);

   sequence s_read_seen(logic [7:0] target);
      bus_state_r == aio_pkg::BUS_IDLE && I_AVS_READ && cur_idx == target;
   endsequence
   sequence s_write_taken(logic [7:0] target);
      acc_wr && cur_idx == target;
   endsequence

   a_bus_answer: assert property (bus_state_r == aio_pkg::BUS_IDLE
      && (I_AVS_READ || I_AVS_WRITE) |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
      else $error("answer did not last exactly one cycle");
   a_second_update: assert property (s_write_taken(aio_pkg::IDX_SECOND_CODE)
      && I_AVS_BYTEENABLE[1:0] == 2'h3
      |=> O_SECOND_OUTPUT_CODE == $past(I_AVS_WRITEDATA[11:0]))
      else $error("second code not updated by its write");
   a_first_direct: assert property (s_write_taken(aio_pkg::IDX_FIRST_CODE) && !simul_r
      && I_AVS_BYTEENABLE[1:0] == 2'h3
      |=> O_FIRST_OUTPUT_CODE == $past(I_AVS_WRITEDATA[11:0]))
      else $error("first code not updated in independent mode");
   a_simul_hold: assert property (s_write_taken(aio_pkg::IDX_FIRST_CODE) && simul_r
      |=> $stable(O_FIRST_OUTPUT_CODE))
      else $error("first code moved before the second code write");
   a_soft_start: assert property (s_write_taken(aio_pkg::IDX_SOFT_START)
      && I_AVS_BYTEENABLE[0] && src == aio_pkg::SRC_SOFT |=> O_CONV_START)
      else $error("software start did not pulse");
   a_timer_start: assert property (src == aio_pkg::SRC_TIMER && chain_if.out_edge
      && $stable(start_cfg_r) |=> O_CONV_START)
      else $error("chain edge did not start a conversion");
   a_scan_level: assert property (s_write_taken(aio_pkg::IDX_START_CFG) && I_AVS_BYTEENABLE[0]
      |=> O_SCAN_SELECT == $past(I_AVS_WRITEDATA[aio_pkg::SCAN_BIT]))
      else $error("scan select does not follow its write");
   a_status_read: assert property (s_read_seen(aio_pkg::IDX_STATUS)
      |=> O_AVS_READDATA[7:5] == ~$past({I_QUEUE_FULL, I_QUEUE_HALF, I_QUEUE_EMPTY}))
      else $error("queue status bits have wrong polarity");
   a_flag_clear: assert property (acc_rd && cur_idx == aio_pkg::IDX_INT && set_vec == 4'h0
      |=> (flags_r & $past(O_AVS_READDATA[7:4])) == 4'h0)
      else $error("read did not clear reported flags");
   a_dir_ignore: assert property (s_write_taken(aio_pkg::IDX_DIRECTION)
      && !I_AVS_WRITEDATA[aio_pkg::DIR_QUAL_BIT] |=> $stable(drive_r))
      else $error("unqualified direction write changed a port");
   a_port_readback: assert property (s_read_seen(aio_pkg::IDX_PORT_A) && drive_r[0]
      |=> O_AVS_READDATA[7:0] == $past(port_out_r[0]))
      else $error("port A readback wrong in output mode");
endmodule : aio_regs

// ===== verification/aio_host.sv
// Host model driving the Avalon-MM register port
`timescale 1ns/100ps
module aio_host (
   input wire logic i_clk,
   input wire logic i_waitrequest,
   input wire logic [31:0] i_readdata,
   output logic [9:0] o_address,
   output logic o_read,
   output logic o_write,
   output logic [31:0] o_writedata,
   output logic [3:0] o_byteenable
);
   // Idle bus from time zero
   initial begin
      o_address = 10'h000;
      o_read = 1'b0;
      o_write = 1'b0;
      o_writedata = 32'h0;
      o_byteenable = 4'h0;
   end
   // One access, held until waitrequest is seen low or 64 cycles pass
   task automatic access(input logic w, input logic [7:0] idx, input logic [31:0] d,
      input logic [3:0] be, output logic [31:0] q, output bit ok);
      int n;
      @(posedge i_clk);
      o_address <= {idx, 2'b00};
      o_read <= !w;
      o_write <= w;
      o_writedata <= d;
      o_byteenable <= be;
      ok = 0;
      q = 32'h0;
      for (n = 0; n < 64 && !ok; n++) begin
         @(posedge i_clk);
         if (i_waitrequest === 1'b0) begin
            ok = 1;
            q = i_readdata;
         end
      end
      // Release, scrambling the stale values
      o_read <= 1'b0;
      o_write <= 1'b0;
      o_address <= ~{idx, 2'b00};
      o_writedata <= ~d;
      o_byteenable <= 4'h0;
   endtask : access
endmodule : aio_host

// ===== verification/aio_regs_test.sv
// Self-checking bench for the analog I/O register bank
`timescale 1ns/100ps
module aio_regs_test;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic rd, wr, wreq, cdone = 1'b0, sdone = 1'b0, ext = 1'b0, xclk = 1'b0;
   logic [9:0] addr;
   logic [31:0] wd, rdata, q, v, seed = 32'h9690;
   logic [3:0] be;
   logic [7:0] st = 8'h00, pa_in = 8'h00, pb_in = 8'h00, pa_o, pa_oe, pb_o, pb_oe;
   logic [11:0] c1, c2, m1;
   logic start, scan, chain, irq;
   int mismatches = 0, n_checks = 0, n_start = 0, n0;
   logic [7:0] ens [6] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h0f};
   logic [7:0] dirs [5] = '{8'h80, 8'h12, 8'h82, 8'h90, 8'h92};
   logic [15:0] oes [5] = '{16'hffff, 16'hffff, 16'hff00, 16'h00ff, 16'h0000};
   // Clock and start pulse tally
   initial forever #2 clk = ~clk;
   always @(posedge clk) if (start === 1'b1) n_start++;
   aio_regs aio_regs_inst (.I_CLK(clk), .I_RSTN(rstn), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
      .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(be), .O_AVS_READDATA(rdata),
      .O_AVS_WAITREQUEST(wreq), .I_BIPOLAR(st[0]), .I_SINGLE_ENDED(st[1]),
      .I_HIGH_GAIN_JUMPER(st[2]), .I_FIRST_OUTPUT_RANGE(st[3]), .I_SECOND_OUTPUT_RANGE(st[4]),
      .I_QUEUE_EMPTY(st[5]), .I_QUEUE_HALF(st[6]), .I_QUEUE_FULL(st[7]), .I_CONV_DONE(cdone),
      .I_SCAN_DONE(sdone), .I_EXT_TRIGGER(ext), .I_CNT0_EXT_CLK(xclk), .I_PORT_A_IN(pa_in),
      .I_PORT_B_IN(pb_in), .O_FIRST_OUTPUT_CODE(c1), .O_SECOND_OUTPUT_CODE(c2),
      .O_CONV_START(start), .O_SCAN_SELECT(scan), .O_CHAIN_OUT(chain), .O_IRQ(irq),
      .O_PORT_A_OUT(pa_o), .O_PORT_A_OE(pa_oe), .O_PORT_B_OUT(pb_o), .O_PORT_B_OE(pb_oe));
   aio_host aio_host_inst (.i_clk(clk), .i_waitrequest(wreq), .i_readdata(rdata),
      .o_address(addr), .o_read(rd), .o_write(wr), .o_writedata(wd), .o_byteenable(be));
   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test
   // Compare one result
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Bus access with timeout handling
   task automatic acc(input logic w, input logic [7:0] idx, input logic [31:0] d,
      input logic [3:0] b);
      bit ok;
      aio_host_inst.access(w, idx, d, b, q, ok);
      if (!ok) begin
         mismatches++;
         $display("wrong value waitrequest expected 0 seen 1");
         stop_test();
      end
   endtask : acc
   task automatic rd8(input logic [7:0] idx, input logic [31:0] e, input string nm);
      acc(1'b0, idx, 32'h0, 4'h1);
      chk(nm, e, q);
   endtask : rd8
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // All four interrupt events, queue levels dropped then raised
   task automatic fire();
      @(posedge clk);
      cdone <= 1'b1;
      sdone <= 1'b1;
      st[7:6] <= 2'b00;
      @(posedge clk);
      cdone <= 1'b0;
      sdone <= 1'b0;
      st[7:6] <= 2'b11;
   endtask : fire
   // Start pulses over a window against a range
   task automatic count(input int n, input int lo, input int hi, input string nm);
      repeat (4) @(posedge clk);
      n0 = n_start;
      repeat (n) @(posedge clk);
      chk(nm, 1, (n_start - n0 >= lo) && (n_start - n0 <= hi));
   endtask : count
   // Run length guard
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      $display("wrong value run expected done seen timeout");
      stop_test();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      chk("port enables", 16'h0000, {pa_oe, pb_oe});
      acc(1'b1, aio_pkg::IDX_UPDATE_CFG, 32'h0, 4'h1);
      v = xs();
      m1 = v[11:0];
      acc(1'b1, aio_pkg::IDX_FIRST_CODE, v, 4'h3);
      @(negedge clk);
      chk("first code", m1, c1);
      v = xs();
      acc(1'b1, aio_pkg::IDX_SECOND_CODE, v, 4'h3);
      @(negedge clk);
      chk("second code", v[11:0], c2);
      acc(1'b1, aio_pkg::IDX_UPDATE_CFG, 32'h1, 4'h1);
      v = xs();
      acc(1'b1, aio_pkg::IDX_FIRST_CODE, v, 4'h3);
      @(negedge clk);
      chk("first code held", m1, c1);
      m1 = v[11:0];
      v = xs();
      acc(1'b1, aio_pkg::IDX_SECOND_CODE, v, 4'h3);
      @(negedge clk);
      chk("both codes", {m1, v[11:0]}, {c1, c2});
      $display("test output codes done");
      repeat (4) begin
         v = xs();
         @(posedge clk);
         st <= v[7:0];
         rd8(aio_pkg::IDX_STATUS, {~v[7:5], v[4:0]}, "status");
      end
      $display("test status done");
      foreach (ens[i]) begin
         acc(1'b1, aio_pkg::IDX_INT, ens[i], 4'h1);
         acc(1'b0, aio_pkg::IDX_INT, 32'h0, 4'h1);
         fire();
         repeat (3) @(negedge clk);
         chk("irq", ens[i] != 0, irq);
         rd8(aio_pkg::IDX_INT, {ens[i], 4'h0}, "cause flags");
         @(negedge clk);
         chk("irq cleared", 0, irq);
         rd8(aio_pkg::IDX_INT, 0, "flags after read");
      end
      $display("test interrupts done");
      foreach (dirs[i]) begin
         acc(1'b1, aio_pkg::IDX_DIRECTION, dirs[i], 4'h1);
         @(negedge clk);
         chk("port enables", oes[i], {pa_oe, pb_oe});
         v = xs();
         @(posedge clk);
         pa_in <= v[23:16];
         pb_in <= v[31:24];
         acc(1'b1, aio_pkg::IDX_PORT_A, v[7:0], 4'h1);
         acc(1'b1, aio_pkg::IDX_PORT_B, v[15:8], 4'h1);
         rd8(aio_pkg::IDX_PORT_A, oes[i][15] ? v[7:0] : v[23:16], "port a");
         rd8(aio_pkg::IDX_PORT_B, oes[i][0] ? v[15:8] : v[31:24], "port b");
         chk("port outputs", v[15:0], {pb_o, pa_o});
      end
      rd8(8'h16, 0, "unmapped");
      rd8(aio_pkg::IDX_FIRST_CODE, 0, "write only");
      $display("test ports done");
      acc(1'b1, aio_pkg::IDX_START_CFG, 32'h4, 4'h1);
      @(negedge clk);
      chk("scan select", 1, scan);
      acc(1'b1, aio_pkg::IDX_START_CFG, 32'h0, 4'h1);
      n0 = n_start;
      acc(1'b1, aio_pkg::IDX_SOFT_START, xs(), 4'h1);
      repeat (3) @(negedge clk);
      chk("soft starts", 1, n_start - n0);
      acc(1'b1, aio_pkg::IDX_TIMER_DIV, 32'h0101, 4'h3);
      acc(1'b1, aio_pkg::IDX_START_CFG, 32'h1, 4'h1);
      count(80, 9, 11, "timer starts");
      acc(1'b1, aio_pkg::IDX_START_CFG, 32'h9, 4'h1);
      count(80, 9, 11, "falling starts");
      acc(1'b1, aio_pkg::IDX_START_CFG, 32'h3, 4'h1);
      count(80, 0, 0, "reserved starts");
      acc(1'b1, aio_pkg::IDX_START_CFG, 32'h2, 4'h1);
      count(80, 0, 0, "held starts");
      @(posedge clk);
      ext <= 1'b1;
      count(80, 8, 11, "trigger starts");
      // Counter 0 on the external pin, then on the internal tick
      acc(1'b1, aio_pkg::IDX_START_CFG, 32'h10, 4'h1);
      acc(1'b0, aio_pkg::IDX_CNT0, 32'h0, 4'h1);
      v = q;
      repeat (3) begin
         @(posedge clk);
         xclk <= 1'b1;
         @(posedge clk);
         xclk <= 1'b0;
      end
      rd8(aio_pkg::IDX_CNT0, {16'h0, v[15:0] + 16'h0003}, "counter 0 external");
      acc(1'b1, aio_pkg::IDX_START_CFG, 32'h0, 4'h1);
      acc(1'b0, aio_pkg::IDX_CNT0, 32'h0, 4'h1);
      v = q;
      repeat (250) @(posedge clk);
      acc(1'b0, aio_pkg::IDX_CNT0, 32'h0, 4'h1);
      chk("counter 0 internal", 1, (q[15:0] - v[15:0] >= 10) && (q[15:0] - v[15:0] <= 11));
      $display("test starts done");
      stop_test();
   end
endmodule : aio_regs_test
